/* File: src/cfg_menu.sv */
/*
 * Configuration menu: button hold entry, clock/calendar and screen-enable
 * editing, screen sequencer and a plain register port.
 * Assumes buttons are raw asynchronous levels, active high, debounced
 * outside; the settings store answers on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - enter configuration only after inc, dec and button_a held together eight seconds
// - every changed setting is sent to non-volatile store and restored on a load in run mode
// - twelve menu headings, time first, analog output last, in fixed order
// - on format screen either edit button toggles 12-hour and 24-hour
// - hour spans 1-12 or 0-23 by format; inc raises, dec lowers
// - half-day selector only in 12-hour format, toggled by either button
// - minute spans 0-59; inc raises, dec lowers
// - day spans 1-31; inc raises, dec lowers
// - month spans 1-12; inc raises, dec lowers
// - year spans 2014-2099; inc raises, dec lowers
// - five screen enables toggle yes/no on either button
// - default: temperature screen on, other four screens off
// - auto-scroll flag toggles yes/no, default no
// - without auto-scroll, next button in run mode moves to next enabled screen
// - scrolling only with two or more enabled screens
// - no enabled screen shows temperature
// - order temperature, humidity, CO2, VOC, time, wrapping, disabled skipped
module cfg_menu #(
    parameter longint unsigned HOLD_CYCLES = cfg_menu_pkg::HOLD_CYCLES,
    parameter longint unsigned DWELL_CYCLES = cfg_menu_pkg::DWELL_CYCLES
) (
    input wire logic clock,
    input wire logic rstn,
    input wire cfg_menu_pkg::buttons_t buttons,
    input wire logic [cfg_menu_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic nv_load_valid,
    input wire cfg_menu_pkg::settings_t nv_load_data,
    output logic nv_store_valid,
    output cfg_menu_pkg::settings_t nv_store_data,
    output logic config_mode,
    output cfg_menu_pkg::heading_t heading,
    output cfg_menu_pkg::field_t field,
    output cfg_menu_pkg::screen_t screen,
    output cfg_menu_pkg::settings_t settings
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (HOLD_CYCLES < 2 || HOLD_CYCLES >= 64'h1_0000_0000) begin : g_bad_hold
        $error("HOLD_CYCLES out of range");
    end
    if (DWELL_CYCLES < 2 || DWELL_CYCLES >= 64'h1_0000_0000) begin : g_bad_dwell
        $error("DWELL_CYCLES out of range");
    end

    localparam logic [31:0] HOLD_LAST = 32'(HOLD_CYCLES - 1);
    localparam logic [31:0] DWELL_LAST = 32'(DWELL_CYCLES - 1);

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------
    function automatic logic [11:0] step(input logic [11:0] v, input logic up,
                                         input logic [11:0] lo, input logic [11:0] hi);
        if (up) begin
            step = (v >= hi) ? lo : v + 12'h001;
        end else begin
            step = (v <= lo) ? hi : v - 12'h001;
        end
    endfunction

    function automatic logic [2:0] count_en(input logic [4:0] en);
        count_en = 3'h0;
        for (int i = 0; i < cfg_menu_pkg::NUM_SCREENS; i++) begin
            count_en = count_en + {2'b00, en[i]};
        end
    endfunction

    // next enabled screen after cur, wrapping; temperature when none
    function automatic cfg_menu_pkg::screen_t next_screen(input cfg_menu_pkg::screen_t cur,
                                                          input logic [4:0] en);
        logic [2:0] idx;
        next_screen = cfg_menu_pkg::SCR_TEMP;
        idx = cur;
        for (int i = 0; i < cfg_menu_pkg::NUM_SCREENS; i++) begin
            idx = (idx == 3'(cfg_menu_pkg::NUM_SCREENS - 1)) ? 3'h0 : idx + 3'h1;
            if (en[idx] && next_screen == cfg_menu_pkg::SCR_TEMP && !en[0]) begin
                next_screen = cfg_menu_pkg::screen_t'(idx);
            end
        end
        idx = cur;
        for (int i = cfg_menu_pkg::NUM_SCREENS - 1; i >= 0; i--) begin
            if (en[(32'(cur) + 32'(i) + 1) % cfg_menu_pkg::NUM_SCREENS]) begin
                idx = 3'((32'(cur) + 32'(i) + 1) % cfg_menu_pkg::NUM_SCREENS);
            end
        end
        if (en != 5'h00) begin
            next_screen = cfg_menu_pkg::screen_t'(idx);
        end
    endfunction

    // ------------------------------------------------------------------
    // reset release and button synchronisers
    // ------------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    logic [3:0] btn_meta_q;
    logic [3:0] btn_sync_q;
    logic [3:0] btn_prev_q;
    logic [3:0] btn_rise;

    for (genvar i = 0; i < 4; i++) begin : g_btn_sync
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                btn_meta_q[i] <= 1'b0;
                btn_sync_q[i] <= 1'b0;
                btn_prev_q[i] <= 1'b0;
            end else begin
                btn_meta_q[i] <= buttons[i];
                btn_sync_q[i] <= btn_meta_q[i];
                btn_prev_q[i] <= btn_sync_q[i];
            end
        end
        assign btn_rise[i] = btn_sync_q[i] & ~btn_prev_q[i];
    end

    // bit order follows buttons_t: inc, dec, button_a, next
    logic inc_lvl, dec_lvl, a_lvl;
    logic inc_edge, dec_edge, a_edge, next_edge;
    assign inc_lvl = btn_sync_q[3];
    assign dec_lvl = btn_sync_q[2];
    assign a_lvl = btn_sync_q[1];
    assign inc_edge = btn_rise[3];
    assign dec_edge = btn_rise[2];
    assign a_edge = btn_rise[1];
    assign next_edge = btn_rise[0];

    // ------------------------------------------------------------------
    // mode control
    // ------------------------------------------------------------------
    cfg_menu_pkg::mode_t mode_q;
    logic [31:0] hold_cnt_q;
    logic hold_done_q;
    logic combo;
    logic exit_req;

    assign combo = inc_lvl & dec_lvl & a_lvl;
    assign exit_req = reg_wr && reg_addr == cfg_menu_pkg::REG_CTRL
                      && reg_wdata[cfg_menu_pkg::CTRL_EXIT_BIT];

    // a hold must be released before it can toggle the mode again
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= cfg_menu_pkg::MODE_RUN;
            hold_cnt_q <= 32'h0000_0000;
            hold_done_q <= 1'b0;
        end else begin
            if (!combo) begin
                hold_cnt_q <= 32'h0000_0000;
                hold_done_q <= 1'b0;
            end else if (!hold_done_q) begin
                hold_cnt_q <= hold_cnt_q + 32'h0000_0001;
            end
            if (combo && !hold_done_q && hold_cnt_q == HOLD_LAST) begin
                hold_done_q <= 1'b1;
                mode_q <= (mode_q == cfg_menu_pkg::MODE_RUN) ? cfg_menu_pkg::MODE_CONFIG
                                                             : cfg_menu_pkg::MODE_RUN;
            end else if (exit_req) begin
                mode_q <= cfg_menu_pkg::MODE_RUN;
            end
        end
    end

    // ------------------------------------------------------------------
    // menu navigation
    // ------------------------------------------------------------------
    cfg_menu_pkg::heading_t heading_q;
    cfg_menu_pkg::field_t field_q;
    cfg_menu_pkg::settings_t set_q;

    function automatic cfg_menu_pkg::field_t first_field(input cfg_menu_pkg::heading_t h);
        unique case (h)
            cfg_menu_pkg::HDG_TIME: first_field = cfg_menu_pkg::FLD_FORMAT;
            cfg_menu_pkg::HDG_DATE: first_field = cfg_menu_pkg::FLD_DAY;
            cfg_menu_pkg::HDG_SCREEN: first_field = cfg_menu_pkg::FLD_EN_TEMP;
            default: first_field = cfg_menu_pkg::FLD_NONE;
        endcase
    endfunction

    function automatic cfg_menu_pkg::field_t next_field(input cfg_menu_pkg::field_t f,
                                                        input logic fmt24);
        unique case (f)
            cfg_menu_pkg::FLD_HOUR: next_field = fmt24 ? cfg_menu_pkg::FLD_MINUTE
                                                       : cfg_menu_pkg::FLD_HALF_DAY;
            cfg_menu_pkg::FLD_MINUTE: next_field = cfg_menu_pkg::FLD_FORMAT;
            cfg_menu_pkg::FLD_YEAR: next_field = cfg_menu_pkg::FLD_DAY;
            cfg_menu_pkg::FLD_SCROLL: next_field = cfg_menu_pkg::FLD_EN_TEMP;
            cfg_menu_pkg::FLD_NONE: next_field = cfg_menu_pkg::FLD_NONE;
            default: next_field = cfg_menu_pkg::field_t'(f + 4'h1);
        endcase
    endfunction

    // button_a steps fields, next steps headings while configuring
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            heading_q <= cfg_menu_pkg::HDG_TIME;
            field_q <= cfg_menu_pkg::FLD_FORMAT;
        end else if (mode_q == cfg_menu_pkg::MODE_RUN) begin
            heading_q <= cfg_menu_pkg::HDG_TIME;
            field_q <= cfg_menu_pkg::FLD_FORMAT;
        end else if (next_edge) begin
            heading_q <= (heading_q == cfg_menu_pkg::HDG_ANALOG) ? cfg_menu_pkg::HDG_TIME
                         : cfg_menu_pkg::heading_t'(heading_q + 4'h1);
            field_q <= first_field((heading_q == cfg_menu_pkg::HDG_ANALOG)
                         ? cfg_menu_pkg::HDG_TIME : cfg_menu_pkg::heading_t'(heading_q + 4'h1));
        end else if (a_edge && !inc_lvl && !dec_lvl) begin
            field_q <= next_field(field_q, set_q.fmt24);
        end else if (set_q.fmt24 && field_q == cfg_menu_pkg::FLD_HALF_DAY) begin
            field_q <= cfg_menu_pkg::FLD_MINUTE;
        end
    end

    // ------------------------------------------------------------------
    // setting edits and non-volatile store
    // ------------------------------------------------------------------
    logic edit;
    logic up;
    logic store_q;

    // a lone inc or dec press; presses during the three-button hold do not edit
    assign edit = (mode_q == cfg_menu_pkg::MODE_CONFIG) && (inc_edge ^ dec_edge) && !a_lvl;
    assign up = inc_edge;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            set_q <= cfg_menu_pkg::SETTINGS_RST;
            store_q <= 1'b0;
        end else begin
            store_q <= edit && field_q != cfg_menu_pkg::FLD_NONE;
            if (nv_load_valid && mode_q == cfg_menu_pkg::MODE_RUN) begin
                set_q <= nv_load_data;
            end else if (edit) begin
                unique case (field_q)
                    cfg_menu_pkg::FLD_FORMAT: begin
                        set_q.fmt24 <= ~set_q.fmt24;
                        if (set_q.fmt24) begin
                            set_q.pm <= set_q.hour >= cfg_menu_pkg::HALF_DAY_HOURS;
                            if (set_q.hour == 5'h00) begin
                                set_q.hour <= cfg_menu_pkg::HALF_DAY_HOURS;
                            end else if (set_q.hour > cfg_menu_pkg::HALF_DAY_HOURS) begin
                                set_q.hour <= set_q.hour - cfg_menu_pkg::HALF_DAY_HOURS;
                            end
                        end else if (set_q.hour == cfg_menu_pkg::HALF_DAY_HOURS) begin
                            set_q.hour <= set_q.pm ? cfg_menu_pkg::HALF_DAY_HOURS : 5'h00;
                        end else if (set_q.pm) begin
                            set_q.hour <= set_q.hour + cfg_menu_pkg::HALF_DAY_HOURS;
                        end
                    end
                    cfg_menu_pkg::FLD_HOUR: begin
                        set_q.hour <= set_q.fmt24
                            ? 5'(step(12'(set_q.hour), up, cfg_menu_pkg::HOUR24_MIN,
                                      cfg_menu_pkg::HOUR24_MAX))
                            : 5'(step(12'(set_q.hour), up, cfg_menu_pkg::HOUR12_MIN,
                                      cfg_menu_pkg::HOUR12_MAX));
                    end
                    cfg_menu_pkg::FLD_HALF_DAY: set_q.pm <= ~set_q.pm;
                    cfg_menu_pkg::FLD_MINUTE: set_q.minute <= 6'(step(12'(set_q.minute), up,
                        cfg_menu_pkg::MINUTE_MIN, cfg_menu_pkg::MINUTE_MAX));
                    cfg_menu_pkg::FLD_DAY: set_q.day <= 5'(step(12'(set_q.day), up,
                        cfg_menu_pkg::DAY_MIN, cfg_menu_pkg::DAY_MAX));
                    cfg_menu_pkg::FLD_MONTH: set_q.month <= 4'(step(12'(set_q.month), up,
                        cfg_menu_pkg::MONTH_MIN, cfg_menu_pkg::MONTH_MAX));
                    cfg_menu_pkg::FLD_YEAR: set_q.year <= step(set_q.year, up,
                        cfg_menu_pkg::YEAR_MIN, cfg_menu_pkg::YEAR_MAX);
                    cfg_menu_pkg::FLD_EN_TEMP, cfg_menu_pkg::FLD_EN_HUM,
                    cfg_menu_pkg::FLD_EN_CO2, cfg_menu_pkg::FLD_EN_VOC,
                    cfg_menu_pkg::FLD_EN_TIME: begin
                        set_q.screen_en[3'(field_q - cfg_menu_pkg::FLD_EN_TEMP)] <=
                            ~set_q.screen_en[3'(field_q - cfg_menu_pkg::FLD_EN_TEMP)];
                    end
                    cfg_menu_pkg::FLD_SCROLL: set_q.auto_scroll <= ~set_q.auto_scroll;
                    cfg_menu_pkg::FLD_NONE: set_q <= set_q;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // screen sequencer
    // ------------------------------------------------------------------
    cfg_menu_pkg::screen_t screen_q;
    logic [31:0] dwell_cnt_q;
    logic [2:0] n_en;
    logic scrolling;
    logic dwell_done;

    assign n_en = count_en(set_q.screen_en);
    assign scrolling = mode_q == cfg_menu_pkg::MODE_RUN && n_en >= 3'h2;
    assign dwell_done = dwell_cnt_q == DWELL_LAST;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dwell_cnt_q <= 32'h0000_0000;
        end else if (!scrolling || !set_q.auto_scroll || dwell_done) begin
            dwell_cnt_q <= 32'h0000_0000;
        end else begin
            dwell_cnt_q <= dwell_cnt_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            screen_q <= cfg_menu_pkg::SCR_TEMP;
        end else if (n_en == 3'h0) begin
            screen_q <= cfg_menu_pkg::SCR_TEMP;
        end else if (!set_q.screen_en[screen_q]) begin
            screen_q <= next_screen(screen_q, set_q.screen_en);
        end else if (scrolling && (set_q.auto_scroll ? dwell_done : next_edge)) begin
            screen_q <= next_screen(screen_q, set_q.screen_en);
        end
    end

    // ------------------------------------------------------------------
    // register port
    // ------------------------------------------------------------------
    logic [31:0] rdata_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                cfg_menu_pkg::REG_STATUS: rdata_q <= {16'h0000, 1'b0, screen_q, field_q,
                                                      heading_q, 3'b000, mode_q};
                cfg_menu_pkg::REG_SETTINGS_LO: rdata_q <= set_q[31:0];
                cfg_menu_pkg::REG_SETTINGS_HI: rdata_q <= {24'h00_0000, set_q[39:32]};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_q;
    assign nv_store_valid = store_q;
    assign nv_store_data = set_q;
    assign config_mode = mode_q == cfg_menu_pkg::MODE_CONFIG;
    assign heading = heading_q;
    assign field = field_q;
    assign screen = screen_q;
    assign settings = set_q;

endmodule // cfg_menu

`default_nettype wire

/* File: src/cfg_menu_pkg.sv */
/*
 * Shared constants, types and register map of the front-panel configuration
 * menu. Assumes a single 250 MHz system clock and a plain register port.
 */
package cfg_menu_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam longint unsigned CLK_HZ = 64'd250_000_000;
    localparam longint unsigned HOLD_TIME_S = 64'd8;
    localparam longint unsigned HOLD_CYCLES = HOLD_TIME_S * CLK_HZ;
    localparam longint unsigned DWELL_TIME_S = 64'd5;
    localparam longint unsigned DWELL_CYCLES = DWELL_TIME_S * CLK_HZ;

    // ------------------------------------------------------------------
    // setting ranges
    // ------------------------------------------------------------------
    localparam logic [11:0] HOUR12_MIN = 12'h001;
    localparam logic [11:0] HOUR12_MAX = 12'h00c;
    localparam logic [11:0] HOUR24_MIN = 12'h000;
    localparam logic [11:0] HOUR24_MAX = 12'h017;
    localparam logic [11:0] MINUTE_MIN = 12'h000;
    localparam logic [11:0] MINUTE_MAX = 12'h03b;
    localparam logic [11:0] DAY_MIN = 12'h001;
    localparam logic [11:0] DAY_MAX = 12'h01f;
    localparam logic [11:0] MONTH_MIN = 12'h001;
    localparam logic [11:0] MONTH_MAX = 12'h00c;
    localparam logic [11:0] YEAR_MIN = 12'h7de;
    localparam logic [11:0] YEAR_MAX = 12'h833;
    localparam logic [4:0] HALF_DAY_HOURS = 5'h0c;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_SETTINGS_LO = 8'h08;
    localparam logic [7:0] REG_SETTINGS_HI = 8'h0c;
    localparam int CTRL_EXIT_BIT = 0;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    localparam int NUM_SCREENS = 5;

    typedef enum logic [2:0] {
        SCR_TEMP, SCR_HUM, SCR_CO2, SCR_VOC, SCR_TIME
    } screen_t;

    typedef enum logic [3:0] {
        HDG_TIME, HDG_DATE, HDG_SCREEN, HDG_TEMP, HDG_HUM, HDG_CO2, HDG_VOC,
        HDG_SETPOINT, HDG_RELAY_ONE, HDG_RELAY_TWO, HDG_SAMPLES, HDG_ANALOG
    } heading_t;

    typedef enum logic [3:0] {
        FLD_FORMAT, FLD_HOUR, FLD_HALF_DAY, FLD_MINUTE, FLD_DAY, FLD_MONTH,
        FLD_YEAR, FLD_EN_TEMP, FLD_EN_HUM, FLD_EN_CO2, FLD_EN_VOC, FLD_EN_TIME,
        FLD_SCROLL, FLD_NONE
    } field_t;

    typedef enum logic {MODE_RUN, MODE_CONFIG} mode_t;

    typedef struct packed {
        logic inc;
        logic dec;
        logic button_a;
        logic next;
    } buttons_t;

    typedef struct packed {
        logic fmt24;
        logic [4:0] hour;
        logic pm;
        logic [5:0] minute;
        logic [4:0] day;
        logic [3:0] month;
        logic [11:0] year;
        logic [4:0] screen_en;
        logic auto_scroll;
    } settings_t;

    localparam settings_t SETTINGS_RST = '{
        fmt24: 1'b0, hour: 5'h0c, pm: 1'b0, minute: 6'h00, day: 5'h01,
        month: 4'h1, year: 12'h7de, screen_en: 5'h01, auto_scroll: 1'b0
    };

endpackage

/* File: dv/cfg_menu_monitor.sv */
/* Checker for the configuration menu ports.
   Assumes bind onto cfg_menu, hold count handed on. */
`timescale 1ns/1ps
`default_nettype none
module cfg_menu_monitor #(
    parameter longint unsigned HOLD_CYCLES = cfg_menu_pkg::HOLD_CYCLES
) (
    input wire logic clock,
    input wire logic rstn,
    input wire cfg_menu_pkg::buttons_t buttons,
    input wire logic nv_store_valid,
    input wire cfg_menu_pkg::settings_t nv_store_data,
    input wire logic config_mode,
    input wire cfg_menu_pkg::heading_t heading,
    input wire cfg_menu_pkg::field_t field,
    input wire cfg_menu_pkg::screen_t screen,
    input wire cfg_menu_pkg::settings_t settings
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    logic [31:0] held_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            held_q <= '0;
        end else if (buttons.inc && buttons.dec && buttons.button_a) begin
            held_q <= held_q + 32'h1;
        end else begin
            held_q <= '0;
        end
    end
    sequence s_edit;
        config_mode && $past(config_mode) && $changed(settings);
    endsequence
    // --------------------------------
    // assertions
    // --------------------------------
    chk_enter_hold: assert property (
        $rose(config_mode) |-> held_q >= HOLD_CYCLES) else $error("entered early");
    chk_store_after_edit: assert property (
        s_edit |-> nv_store_valid) else $error("edit not stored");
    chk_store_data: assert property (
        nv_store_valid |-> nv_store_data == settings ##1 !nv_store_valid) else $error("bad store");
    chk_heading_step: assert property (
        config_mode && $past(config_mode) && $changed(heading) |-> heading ==
        (($past(heading) == cfg_menu_pkg::HDG_ANALOG) ? 4'h0 : $past(heading) + 4'h1))
        else $error("heading order");
    chk_hour_range: assert property (
        settings.fmt24 ? settings.hour <= 5'h17 : settings.hour inside {[5'h01:5'h0c]})
        else $error("hour range");
    chk_half_day_skip: assert property (
        settings.fmt24 |-> field != cfg_menu_pkg::FLD_HALF_DAY) else $error("half day in 24h");
    chk_minute_range: assert property (
        settings.minute <= 6'h3b) else $error("minute range");
    chk_date_range: assert property (
        settings.day != 5'h00 && settings.month inside {[4'h1:4'hc]} &&
        settings.year inside {[12'h7de:12'h833]}) else $error("date range");
    chk_screen_enabled: assert property (
        settings.screen_en != 5'h00 && $stable(settings.screen_en) |->
        settings.screen_en[screen]) else $error("disabled screen shown");
    chk_empty_temp: assert property (
        settings.screen_en == 5'h00 && $past(settings.screen_en) == 5'h00 |->
        screen == cfg_menu_pkg::SCR_TEMP) else $error("no fallback screen");
endmodule // cfg_menu_monitor
bind cfg_menu cfg_menu_monitor #(.HOLD_CYCLES(HOLD_CYCLES)) u_monitor (.clock, .rstn,
    .buttons, .nv_store_valid, .nv_store_data, .config_mode, .heading, .field, .screen,
    .settings);
`default_nettype wire

/* File: dv/btn_person.sv */
/* Person at the front panel pressing button combinations.
   Assumes one caller at a time; released buttons read low. */
`timescale 1ns/1ps
`default_nettype none
module btn_person (
    input wire logic clock,
    output var cfg_menu_pkg::buttons_t buttons
);
    initial buttons = '0;
    // release long enough for the synchroniser to see a fresh rise next time
    task automatic press(input logic [3:0] mask, input int n);
        @(posedge clock);
        buttons <= mask;
        repeat (n) @(posedge clock);
        buttons <= '0;
        repeat (4) @(posedge clock);
    endtask
endmodule // btn_person
`default_nettype wire

/* File: dv/tb.sv */
/* Self-checking bench for the configuration menu.
   Assumes the person model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int HOLD = 20;
    localparam int DWELL = 10;
    logic clock, rstn, reg_wr, reg_rd, nv_load_valid, nv_store_valid, config_mode;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd;
    logic [2:0] es;
    cfg_menu_pkg::buttons_t buttons;
    cfg_menu_pkg::settings_t nv_load_data, nv_store_data, settings, ld;
    cfg_menu_pkg::heading_t heading;
    cfg_menu_pkg::field_t field;
    cfg_menu_pkg::screen_t screen;
    int n_mismatch = 0, checks_done = 0, k, gap;
    cfg_menu #(.HOLD_CYCLES(HOLD), .DWELL_CYCLES(DWELL)) u_cfg_menu (.clock, .rstn, .buttons,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .nv_load_valid, .nv_load_data,
        .nv_store_valid, .nv_store_data, .config_mode, .heading, .field, .screen, .settings);
    btn_person u_person (.clock, .buttons);
    // --------------------------------
    // tasks and functions
    // --------------------------------
    task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr <= wr;
        reg_rd <= !wr;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        rd = reg_rdata;
    endtask
    task automatic load(input cfg_menu_pkg::settings_t s);
        @(posedge clock);
        nv_load_valid <= 1'b1;
        nv_load_data <= s;
        @(posedge clock);
        nv_load_valid <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
    endtask
    function automatic logic [39:0] wrap(input int v, input int lo, input int hi);
        return 40'(lo + ((v - lo) % (hi - lo + 1) + hi - lo + 1) % (hi - lo + 1));
    endfunction
    function automatic logic [2:0] nxt(input logic [2:0] cur, input logic [4:0] en);
        for (int i = 1; i <= 5; i++) begin
            if (en[(cur + i) % 5]) return 3'((cur + i) % 5);
        end
        return 3'h0;
    endfunction
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        complete_run();
    end
    initial begin
        k = $urandom(32'h59dd9a66);
        {rstn, reg_wr, reg_rd, nv_load_valid, reg_addr, reg_wdata, nv_load_data} = '0;
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        check("defaults", settings, cfg_menu_pkg::SETTINGS_RST);
        u_person.press(4'h1, 4);
        check("lone screen", screen, 0);
        u_person.press(4'he, HOLD / 2);
        check("short hold", config_mode, 0);
        u_person.press(4'he, HOLD + 6);
        check("long hold", config_mode, 1);
        u_person.press(4'h8, 4);
        check("format", settings.fmt24, 1);
        u_person.press(4'h2, 4);
        u_person.press(4'h4, 4);
        check("hour wrap", settings.hour, 23);
        k = $urandom_range(30, 1);
        repeat (k) u_person.press(4'h8, 4);
        check("hour up", settings.hour, wrap(23 + k, 0, 23));
        u_person.press(4'h2, 4);
        check("skip half day", field, cfg_menu_pkg::FLD_MINUTE);
        u_person.press(4'h4, 4);
        check("minute wrap", settings.minute, 59);
        for (int i = 1; i <= 12; i++) begin
            u_person.press(4'h1, 4);
            check("heading", heading, wrap(i, 0, 11));
            if (i == 1) u_person.press(4'h4, 4);
            if (i == 1) check("day wrap", settings.day, 31);
            if (i == 2) u_person.press(4'h8, 4);
            if (i == 2) check("enable", settings.screen_en, 0);
        end
        bus(1'b1, cfg_menu_pkg::REG_CTRL, 32'h1);
        ld = cfg_menu_pkg::SETTINGS_RST;
        ld.minute = 6'($urandom_range(59));
        ld.screen_en = 5'h13;
        load(ld);
        check("restore", settings, ld);
        bus(1'b1, cfg_menu_pkg::REG_SETTINGS_LO, 32'h0);
        bus(1'b0, cfg_menu_pkg::REG_SETTINGS_LO, 32'h0);
        check("settings word", rd, ld[31:0]);
        es = 3'h0;
        repeat (3) begin
            es = nxt(es, 5'h13);
            u_person.press(4'h1, 4);
            check("manual scroll", screen, es);
        end
        ld.auto_scroll = 1'b1;
        load(ld);
        es = screen;
        for (k = 0; k < 40 && screen === es; k++) begin
            @(posedge clock);
            #1;
        end
        es = screen;
        for (gap = 0; gap < 40 && screen === es; gap++) begin
            @(posedge clock);
            #1;
        end
        check("dwell", gap, DWELL);
        check("auto order", screen, nxt(es, 5'h13));
        ld.screen_en = 5'h00;
        load(ld);
        check("no screen", screen, 0);
        complete_run();
    end
endmodule // tb
`default_nettype wire
